// ==== src/lmro_cfg.svh ====
`ifndef LMRO_CFG_SVH
`define LMRO_CFG_SVH
// Opcode patterns, 14-bit instruction words; also enable bit, irq control address, reset values and return length
`define LMRO_LIT_TOP_VAL    4'hC
`define LMRO_STORE_PFX      7'h01
`define LMRO_RETI_WORD      14'h0009
`define LMRO_CFGLOAD_WORD   14'h0062
`define LMRO_IDLE_MASK      14'h3F9F
`define LMRO_GIE_BIT        7
`define LMRO_IRQ_CTRL_ADDR  7'h0B
`define LMRO_RST_ACC        8'h00
`define LMRO_RST_CFG        8'hFF
`define LMRO_RETI_CYCLES    2
`endif

// ==== src/lmro_core.sv ====
`include "lmro_cfg.svh"
`default_nettype none
module lmro_core
#(
   parameter int PC_W = 13
)
(
   input  wire logic            i_sys_clk,
   input  wire logic            i_rst,
   input  wire logic            i_instr_valid,
   input  wire logic [13:0]     i_instr,
   input  wire logic [PC_W-1:0] i_stack_top,
   output logic                 o_instr_ready,
   output logic [7:0]           o_accumulator,
   output logic [7:0]           o_cfg_reg,
   output logic                 o_global_irq_enable,
   output logic                 o_stack_pop,
   output logic                 o_pc_load,
   output logic [PC_W-1:0]      o_pc_value,
   output logic                 o_pc_advance,
   output logic                 o_file_wr,
   output logic [6:0]           o_file_addr,
   output logic [7:0]           o_file_data,
   output logic                 o_unhandled
);
   lmro_dec_if dec_bus ();
   lmro_decode u_decode
   (
      .bus (dec_bus.dec)
   );
   assign dec_bus.word = i_instr;

   lmro_pkg::lmro_state_e state_r;
   lmro_pkg::lmro_state_e state_nxt;
   logic [7:0]            acc_r;
   logic [7:0]            cfg_r;
   logic                  gie_r;
   logic                  pop_r;
   logic                  pcl_r;
   logic [PC_W-1:0]       pcv_r;
   logic                  adv_r;
   logic                  fwr_r;
   logic [6:0]            fad_r;
   logic [7:0]            fdt_r;
   logic                  unh_r;

   wire logic take;
   wire logic do_lit;
   wire logic do_store;
   wire logic do_reti;
   wire logic do_cfg;
   wire logic do_idle;
   wire logic store_hits_gie;
   wire logic [7:0]      acc_nxt;
   wire logic [7:0]      cfg_nxt;
   wire logic            gie_nxt;
   wire logic            pop_nxt;
   wire logic            pcl_nxt;
   wire logic [PC_W-1:0] pcv_nxt;
   wire logic            adv_nxt;
   wire logic            fwr_nxt;
   wire logic [6:0]      fad_nxt;
   wire logic [7:0]      fdt_nxt;
   wire logic            unh_nxt;
   wire logic            rdy_nxt;

   // Accept a word only while not flushing the second return cycle
   assign take     = i_instr_valid && (state_r == lmro_pkg::LMRO_ST_EXEC);
   assign do_lit   = take && dec_bus.op == lmro_pkg::LMRO_OP_LIT;
   assign do_store = take && dec_bus.op == lmro_pkg::LMRO_OP_STORE;
   assign do_reti  = take && dec_bus.op == lmro_pkg::LMRO_OP_RETI;
   assign do_cfg   = take && dec_bus.op == lmro_pkg::LMRO_OP_CFG;
   assign do_idle  = take && dec_bus.op == lmro_pkg::LMRO_OP_IDLE;
   // A store to the interrupt control register also writes the enable bit
   assign store_hits_gie = do_store && dec_bus.file_addr == `LMRO_IRQ_CTRL_ADDR;

   // Next values; the registers below only capture them
   assign acc_nxt = do_lit ? dec_bus.literal : acc_r;
   assign cfg_nxt = do_cfg ? acc_r : cfg_r;
   // Return wins, though a store can never share its cycle
   assign gie_nxt = do_reti        ? 1'b1 :
                    store_hits_gie ? acc_r[`LMRO_GIE_BIT] : gie_r;
   assign pop_nxt = do_reti;
   assign pcl_nxt = do_reti;
   assign pcv_nxt = do_reti ? i_stack_top : pcv_r;
   assign adv_nxt = do_lit || do_store || do_cfg || do_idle;
   assign fwr_nxt = do_store;
   assign fad_nxt = do_store ? dec_bus.file_addr : fad_r;
   assign fdt_nxt = do_store ? acc_r : fdt_r;
   assign unh_nxt = take && dec_bus.op == lmro_pkg::LMRO_OP_OTHER;
   assign rdy_nxt = state_nxt == lmro_pkg::LMRO_ST_EXEC;

   always_comb
   begin
      case (state_r)
         lmro_pkg::LMRO_ST_EXEC:
            state_nxt = do_reti ? lmro_pkg::LMRO_ST_FLUSH : lmro_pkg::LMRO_ST_EXEC;
         lmro_pkg::LMRO_ST_FLUSH:
            state_nxt = lmro_pkg::LMRO_ST_EXEC;
         default:
            state_nxt = lmro_pkg::LMRO_ST_EXEC;
      endcase
   end

   // One short process per register keeps reset values easy to audit
   always_ff @(posedge i_sys_clk)
   begin
      if (i_rst)
         state_r <= lmro_pkg::LMRO_ST_EXEC;
      else
         state_r <= state_nxt;
   end

   always_ff @(posedge i_sys_clk)
   begin
      if (i_rst)
         acc_r <= `LMRO_RST_ACC;
      else
         acc_r <= acc_nxt;
   end

   always_ff @(posedge i_sys_clk)
   begin
      if (i_rst)
         cfg_r <= `LMRO_RST_CFG;
      else
         cfg_r <= cfg_nxt;
   end

   always_ff @(posedge i_sys_clk)
   begin
      if (i_rst)
         gie_r <= 1'b0;
      else
         gie_r <= gie_nxt;
   end

   // Bus-facing strobes are one-cycle pulses
   always_ff @(posedge i_sys_clk)
   begin
      if (i_rst)
         pop_r <= 1'b0;
      else
         pop_r <= pop_nxt;
   end

   always_ff @(posedge i_sys_clk)
   begin
      if (i_rst)
         pcl_r <= 1'b0;
      else
         pcl_r <= pcl_nxt;
   end

   always_ff @(posedge i_sys_clk)
   begin
      if (i_rst)
         adv_r <= 1'b0;
      else
         adv_r <= adv_nxt;
   end

   always_ff @(posedge i_sys_clk)
   begin
      if (i_rst)
         fwr_r <= 1'b0;
      else
         fwr_r <= fwr_nxt;
   end

   // Words outside this subset are flagged, never silently dropped
   always_ff @(posedge i_sys_clk)
   begin
      if (i_rst)
         unh_r <= 1'b0;
      else
         unh_r <= unh_nxt;
   end

   // Held values: last return target and last store
   always_ff @(posedge i_sys_clk)
   begin
      if (i_rst)
         pcv_r <= '0;
      else
         pcv_r <= pcv_nxt;
   end

   always_ff @(posedge i_sys_clk)
   begin
      if (i_rst)
         fad_r <= 7'h00;
      else
         fad_r <= fad_nxt;
   end

   always_ff @(posedge i_sys_clk)
   begin
      if (i_rst)
         fdt_r <= 8'h00;
      else
         fdt_r <= fdt_nxt;
   end

   // Ready register: low for the flush cycle of a return
   logic rdy_r;
   always_ff @(posedge i_sys_clk)
   begin
      if (i_rst)
         rdy_r <= 1'b1;
      else
         rdy_r <= rdy_nxt;
   end

   assign o_instr_ready       = rdy_r;
   assign o_accumulator       = acc_r;
   assign o_cfg_reg           = cfg_r;
   assign o_global_irq_enable = gie_r;
   assign o_stack_pop         = pop_r;
   assign o_pc_load           = pcl_r;
   assign o_pc_value          = pcv_r;
   assign o_pc_advance        = adv_r;
   assign o_file_wr           = fwr_r;
   assign o_file_addr         = fad_r;
   assign o_file_data         = fdt_r;
   assign o_unhandled         = unh_r;
endmodule
`default_nettype wire

// ==== src/lmro_dec_if.sv ====
`default_nettype none
interface lmro_dec_if;
   logic [13:0]        word;
   lmro_pkg::lmro_op_e op;
   logic [7:0]         literal;
   logic [6:0]         file_addr;
   modport dec (input word, output op, output literal, output file_addr);
   modport core (output word, input op, input literal, input file_addr);
endinterface
`default_nettype wire

// ==== src/lmro_decode.sv ====
`include "lmro_cfg.svh"
`default_nettype none
module lmro_decode
(
   lmro_dec_if.dec bus
);
   wire logic is_lit;
   wire logic is_store;
   wire logic is_reti;
   wire logic is_cfg;
   wire logic is_idle;
   // Don't-care bits of the literal opcode are ignored here; images zero them
   assign is_lit   = bus.word[13:10] == `LMRO_LIT_TOP_VAL;
   assign is_store = bus.word[13:7] == `LMRO_STORE_PFX;
   assign is_reti  = bus.word == `LMRO_RETI_WORD;
   assign is_cfg   = bus.word == `LMRO_CFGLOAD_WORD;
   assign is_idle  = (bus.word & `LMRO_IDLE_MASK) == 14'h0000;
   assign bus.literal   = bus.word[7:0];
   assign bus.file_addr = bus.word[6:0];
   assign bus.op = is_lit   ? lmro_pkg::LMRO_OP_LIT :
                   is_store ? lmro_pkg::LMRO_OP_STORE :
                   is_reti  ? lmro_pkg::LMRO_OP_RETI :
                   is_cfg   ? lmro_pkg::LMRO_OP_CFG :
                   is_idle  ? lmro_pkg::LMRO_OP_IDLE : lmro_pkg::LMRO_OP_OTHER;
endmodule
`default_nettype wire

// ==== src/lmro_pkg.sv ====
`default_nettype none
package lmro_pkg;
   typedef enum logic [1:0] {
      LMRO_ST_EXEC = 2'b01,
      LMRO_ST_FLUSH = 2'b10
   } lmro_state_e;
   typedef enum logic [5:0] {
      LMRO_OP_NONE  = 6'h00,
      LMRO_OP_LIT   = 6'h01,
      LMRO_OP_STORE = 6'h02,
      LMRO_OP_IDLE  = 6'h04,
      LMRO_OP_RETI  = 6'h08,
      LMRO_OP_CFG   = 6'h10,
      LMRO_OP_OTHER = 6'h20
   } lmro_op_e;
endpackage
`default_nettype wire

// ==== test/lmro_core_props.sv ====
`default_nettype none
module lmro_core_props #(parameter int PC_W = 13)
(
   input wire logic            i_sys_clk,
   input wire logic            i_rst,
   input wire logic            i_instr_valid,
   input wire logic [13:0]     i_instr,
   input wire logic [PC_W-1:0] i_stack_top,
   input wire logic            o_instr_ready,
   input wire logic [7:0]      o_accumulator,
   input wire logic [7:0]      o_cfg_reg,
   input wire logic            o_global_irq_enable,
   input wire logic            o_stack_pop,
   input wire logic            o_pc_load,
   input wire logic [PC_W-1:0] o_pc_value,
   input wire logic            o_pc_advance,
   input wire logic            o_file_wr,
   input wire logic [6:0]      o_file_addr,
   input wire logic [7:0]      o_file_data
);
   timeunit 1ns;
   timeprecision 1ns;
   default clocking @(posedge i_sys_clk); endclocking
   default disable iff (i_rst);
   wire take = i_instr_valid && o_instr_ready;
   wire reti = take && i_instr == 14'h0009;
   chk_lit_load: assert property (take && i_instr[13:10] == 4'hC |=>
      o_accumulator == $past(i_instr[7:0]) && o_pc_advance) else $error("literal load wrong");
   chk_store_write: assert property (take && i_instr[13:7] == 7'h01 |=>
      o_file_wr && o_file_addr == $past(i_instr[6:0]) && o_file_data == $past(o_accumulator))
      else $error("store wrong");
   chk_return_pc: assert property (reti |=> o_stack_pop && o_pc_load &&
      o_pc_value == $past(i_stack_top)) else $error("return pc wrong");
   chk_return_irq: assert property (reti |=> o_global_irq_enable)
      else $error("return left irq enable low");
   chk_return_len: assert property (reti |=> !o_instr_ready ##1 o_instr_ready &&
      !o_stack_pop) else $error("return length wrong");
   chk_cfg_load: assert property (take && i_instr == 14'h0062 |=>
      o_cfg_reg == $past(o_accumulator) && o_pc_advance) else $error("config load wrong");
   chk_idle_keep: assert property (take && (i_instr & 14'h3F9F) == 14'h0000 |=>
      o_pc_advance && !o_file_wr && $stable(o_accumulator) && $stable(o_cfg_reg))
      else $error("idle changed state");
   chk_pop_pair: assert property (o_stack_pop |-> o_pc_load && !o_pc_advance)
      else $error("pop without pc load");
   // Store to the irq control register writes the enable from accumulator bit 7
   chk_irq_store: assert property (take && i_instr == 14'h008B |=>
      o_global_irq_enable == $past(o_accumulator[7])) else $error("irq enable store wrong");
endmodule
bind lmro_core lmro_core_props #(.PC_W(PC_W)) props_inst (.i_sys_clk(i_sys_clk),
   .i_rst(i_rst), .i_instr_valid(i_instr_valid), .i_instr(i_instr), .i_stack_top(i_stack_top),
   .o_instr_ready(o_instr_ready), .o_accumulator(o_accumulator), .o_cfg_reg(o_cfg_reg),
   .o_global_irq_enable(o_global_irq_enable), .o_stack_pop(o_stack_pop), .o_pc_load(o_pc_load),
   .o_pc_value(o_pc_value), .o_pc_advance(o_pc_advance), .o_file_wr(o_file_wr),
   .o_file_addr(o_file_addr), .o_file_data(o_file_data));
`default_nettype wire

// ==== test/lmro_prog_mem.sv ====
`default_nettype none
module lmro_prog_mem
(
   input  wire logic   i_sys_clk,
   input  wire logic   i_rst,
   input  wire logic   i_instr_ready,
   output logic        o_instr_valid,
   output logic [13:0] o_instr,
   output logic [12:0] o_stack_top
);
   timeunit 1ns;
   timeprecision 1ns;
   logic [13:0] rom [0:63];
   logic [12:0] stk [0:63];
   int          len = 0;
   int          ptr = 0;
   assign o_instr_valid = ptr < len;
   // Idle bus shows inverted last word, never a stale copy
   assign o_instr = o_instr_valid ? rom[ptr] : ~rom[len-1];
   assign o_stack_top = stk[ptr];
   always @(posedge i_sys_clk)
      if (!i_rst && o_instr_valid && i_instr_ready)
         ptr <= ptr + 1;
endmodule
`default_nettype wire

// ==== test/tb_literal_move_return_ops.sv ====
`include "lmro_cfg.svh"
`default_nettype none
module tb_literal_move_return_ops;
   timeunit 1ns;
   timeprecision 100ps;
   logic        i_sys_clk = 1'b0;
   logic        i_rst = 1'b1;
   wire         vld, rdy, pop, pld, adv, fwr;
   wire  [13:0] ins;
   wire  [12:0] stk, pcv;
   wire  [7:0]  acc, cfg;
   wire         global_irq_enable, unh;
   wire  [32:0] obs = {acc, cfg, global_irq_enable, pld, fwr, unh, pcv};
   logic [32:0] exp_q [$];
   int          n_errors = 0;
   int          samples_checked = 0;
   lmro_prog_mem lmro_prog_mem_inst (.i_sys_clk(i_sys_clk), .i_rst(i_rst), .i_instr_ready(rdy),
      .o_instr_valid(vld), .o_instr(ins), .o_stack_top(stk));
   lmro_core lmro_core_inst (.i_sys_clk(i_sys_clk), .i_rst(i_rst), .i_instr_valid(vld),
      .i_instr(ins), .i_stack_top(stk), .o_instr_ready(rdy), .o_accumulator(acc), .o_cfg_reg(cfg),
      .o_global_irq_enable(global_irq_enable), .o_stack_pop(pop), .o_pc_load(pld), .o_pc_value(pcv),
      .o_pc_advance(adv), .o_file_wr(fwr), .o_file_addr(), .o_file_data(), .o_unhandled(unh));
   initial forever #2.5 i_sys_clk = ~i_sys_clk;
   task automatic final_report();
      $display("checked %0d errors %0d", samples_checked, n_errors);
      if (n_errors == 0 && samples_checked > 0)
         $display("TEST PASSED");
      else
         $display("TEST FAILED");
      $finish;
   endtask
   task automatic check_state(input logic [32:0] got);
      logic [32:0] e;
      e = exp_q.size() ? exp_q.pop_front() : 33'hX;
      samples_checked++;
      if (got !== e)
      begin
         n_errors++;
         $display("ERROR t=%0t exp %h got %h", $time, e, got);
      end
   endtask
   always @(posedge i_sys_clk)
      if (i_rst === 1'b0 && (adv === 1'b1 || pld === 1'b1 || unh === 1'b1))
         check_state(obs);
   initial
   begin
      logic [7:0]  a;
      logic [7:0]  c;
      logic        g;
      logic [12:0] p;
      logic [13:0] w;
      logic [12:0] s;
      int          k;
      void'($urandom(76755));
      a = `LMRO_RST_ACC;
      c = `LMRO_RST_CFG;
      g = 1'b0;
      p = 13'h0000;
      for (int i = 0; i < 64; i++)
      begin
         k = $urandom % 6;
         s = 13'($urandom);
         w = 14'($urandom);
         case (k)
            0: begin w = {6'h30, w[7:0]}; a = w[7:0]; end
            1:
            begin
               // Half of the stores aim at the irq control register
               w = {7'h01, w[13] ? `LMRO_IRQ_CTRL_ADDR : w[6:0]};
               if (w[6:0] == `LMRO_IRQ_CTRL_ADDR)
                  g = a[7];
            end
            2: begin w = 14'h0009; g = 1'b1; p = s; end
            3: begin w = 14'h0062; c = a; end
            4: w = {7'h00, w[1:0], 5'h00};
            default: w = {6'h38, w[7:0]};
         endcase
         lmro_prog_mem_inst.rom[i] = w;
         lmro_prog_mem_inst.stk[i] = s;
         exp_q.push_back({a, c, g, k == 2, k == 1, k == 5, p});
      end
      lmro_prog_mem_inst.len = 64;
      repeat (20) @(posedge i_sys_clk);
      i_rst <= 1'b0;
      for (int t = 0; t < 400 && exp_q.size() > 0; t++) @(posedge i_sys_clk);
      repeat (3) @(posedge i_sys_clk);
      if (exp_q.size() > 0) n_errors++;
      final_report();
   end
   initial
   begin
      #20000;
      n_errors++;
      final_report();
   end
endmodule
`default_nettype wire
